// ===== src/sdm_top.sv
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
// Summary of operation
// RULE1 - Data zero drives speed on channel one, load on two, unipolar range.
// RULE2 - Speed span sets full-scale speed; zero falls back to top speed.
// RULE3 - Load meter low-pass filtered, steps of 3.5 ms, zero means 226 ms; the code rounds the time constant down to a power of two ticks, 32768 at most.
// RULE4 - Force bit drives both meters to full scale, adjustment mode.
// RULE5 - Speed and load full scale trimmed in thousandths, default 938.
// RULE6 - Load span is volts at 120 percent load; zero means 10 V.
// RULE7 - Internal data: data times gain over 256, plus mid-scale offset.
// RULE8 - Each channel has its own signed gain in 256ths.
// RULE9 - Gain zero acts as unity gain 256.
// RULE10 - Data 80 to 87 output whole 16-bit words through the gain.
// RULE11 - Controller word: enable bit 0, param 6, fault clear 7, caps 8-10.
// RULE12 - Enable request switches the converter main circuit on.
// RULE13 - Run and orient commands ignored until ready-on reached.
// RULE14 - Enable dropped while rotating cuts motor current, motor coasts.
// RULE15 - Fault clear resets alarms; while rotating also removes motor power.
// RULE16 - Any input selector set to 9 maps its input to fault clear.
// RULE17 - Parameter conversion from the PC sets the param convert bit.
// RULE18 - Each channel result saturates to codes 0 to 255.
module sdm_top
	import sdm_pkg::*;
#(
	parameter int unsigned READY_CYC = sdm_pkg::READY_DELAY_CYC,
	parameter int unsigned TICK_CYC  = sdm_pkg::OUT_CYCLE_CYC
)(
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	output logic                        irq_o,
	// Drive data
	input  wire logic signed [15:0]     speed_fb_i,
	input  wire logic signed [15:0]     cur_cmd_i,
	input  wire logic signed [15:0]     cur_fb_i,
	input  wire logic [15:0]            load_i,
	input  wire logic [6:0][15:0]       ctrl_aux_i,
	// Sequence inputs
	input  wire logic                   motor_rotating_i,
	input  wire logic                   run_fwd_i,
	input  wire logic                   run_rev_i,
	input  wire logic                   orient_i,
	input  wire logic                   pc_param_convert_i,
	input  wire logic [GP_INPUTS-1:0]   gp_in_i,
	// Converter codes
	output logic      [7:0]             dac1_code_o,
	output logic      [7:0]             dac2_code_o,
	output logic                        dac_strobe_o,
	// Sequence outputs
	output logic                        main_circuit_on_o,
	output logic                        ready_on_reached_o,
	output logic                        motor_current_en_o,
	output logic                        fault_clear_request_o,
	output logic                        param_convert_request_o,
	output logic [2:0]                  torque_cap_sel_o,
	output logic                        run_fwd_o,
	output logic                        run_rev_o,
	output logic                        orient_o,
	output logic                        adjust_mode_o
);
	import sdm_pkg::*;

	// ==========================================================
	// Register file and bus
	logic [31:0]      cfg_q [CFG_WORDS];
	logic [31:0]      cfg_d [CFG_WORDS];
	logic [15:0]      cmd_q, cmd_d;
	logic [IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, evt;
	logic             ack_q, ack_d;
	logic [31:0]      rdat_q, rdat_d;
	logic             wr;
	logic [3:0]       idx;

	assign wr  = ack_q & wb_cyc_i & wb_stb_i & wb_we_i;
	assign idx = wb_adr_i[5:2];

	// ==========================================================
	// Sequence state
	sdm_ready_t   st_q, st_d;
	logic [24:0]  rdy_cnt_q, rdy_cnt_d;
	logic [23:0]  tick_cnt_q, tick_cnt_d;
	logic         tick;
	logic         en_prev_q, fault_prev_q;
	logic         enable_req, fault_clear, gp_fault;

	// ==========================================================
	// Config fields
	logic [7:0]         dn [2];
	logic signed [15:0] gain [2];
	logic               force_fs;
	logic [14:0]        top_spd, spd_span, load_tc;
	logic [9:0]         spd_trim, load_trim;
	logic [3:0]         load_span;

	always_comb begin
		dn[0]     = cfg_q[1][7:0];
		dn[1]     = cfg_q[1][15:8];
		force_fs  = cfg_q[1][SEL_FORCE_BIT];
		gain[0]   = cfg_q[2][15:0];
		gain[1]   = cfg_q[3][15:0];
		top_spd   = cfg_q[4][14:0];
		spd_span  = cfg_q[5][14:0];
		load_tc   = cfg_q[6][14:0];
		spd_trim  = cfg_q[7][9:0];
		load_trim = cfg_q[8][9:0];
		load_span = cfg_q[9][3:0];
	end

	always_comb begin
		gp_fault = 1'b0;
		for (int k = 0; k < GP_INPUTS; k++) begin
			if (cfg_q[10 + k / 6][(k % 6) * GP_SEL_W +: GP_SEL_W] == GP_FAULT_CLEAR) begin
				gp_fault = gp_fault | gp_in_i[k]; // RULE16
			end
		end
		enable_req  = cmd_q[CMD_ENABLE_BIT];
		fault_clear = cmd_q[CMD_FAULT_BIT] | gp_fault; // RULE15
	end

	// ==========================================================
	// Bus decode
	always_comb begin
		ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
		rdat_d = rdat_q;
		cfg_d  = cfg_q;
		cmd_d  = cmd_q;
		mask_d = mask_q;
		stat_d = stat_q;
		if (ack_d) begin
			if (wb_adr_i == OFS_STATE) begin
				rdat_d = {27'h0, adjust_mode_o, fault_clear, motor_current_en_o,
					ready_on_reached_o, main_circuit_on_o};
			end else if (wb_adr_i == OFS_IRQ_STAT) begin
				rdat_d = {28'h0, stat_q};
			end else if (wb_adr_i == OFS_IRQ_MASK) begin
				rdat_d = {28'h0, mask_q};
			end else if (wb_adr_i[1:0] == 2'b00 && wb_adr_i < OFS_STATE) begin
				rdat_d = cfg_q[idx] & CFG_MASK[idx];
			end else begin
				rdat_d = 32'h0;
			end
		end
		if (wr) begin
			if (wb_adr_i == OFS_CMD) begin
				cmd_d = 16'(sdm_lane({16'h0, cmd_q}, wb_dat_i, wb_sel_i));
			end else if (wb_adr_i == OFS_IRQ_MASK) begin
				mask_d = IRQ_W'(sdm_lane({28'h0, mask_q}, wb_dat_i, wb_sel_i));
			end else if (wb_adr_i == OFS_IRQ_STAT) begin
				stat_d = stat_q & ~(wb_dat_i[IRQ_W-1:0] & {IRQ_W{wb_sel_i[0]}});
			end else if (wb_adr_i[1:0] == 2'b00 && wb_adr_i < OFS_STATE) begin
				cfg_d[idx] = sdm_lane(cfg_q[idx], wb_dat_i, wb_sel_i) & CFG_MASK[idx];
			end
		end
		// Hardware sets win over a same-cycle software clear
		if (pc_param_convert_i) begin
			cmd_d[CMD_PARAM_BIT] = 1'b1; // RULE17
		end
		stat_d = stat_d | evt;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q  <= CFG_RST;
			cmd_q  <= 16'h0000;
			mask_q <= '0;
			stat_q <= '0;
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			cfg_q  <= cfg_d;
			cmd_q  <= cmd_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	// ==========================================================
	// Ready-on sequence
	always_comb begin
		st_d       = st_q;
		rdy_cnt_d  = rdy_cnt_q;
		tick_cnt_d = (tick_cnt_q == 24'(TICK_CYC - 1)) ? 24'h0 : tick_cnt_q + 24'h1;
		case (st_q)
			SDM_OFF: begin
				rdy_cnt_d = '0;
				if (enable_req) begin
					st_d = SDM_CHARGE; // RULE12
				end
			end
			SDM_CHARGE: begin
				rdy_cnt_d = rdy_cnt_q + 25'h1;
				if (!enable_req) begin
					st_d = SDM_OFF;
				end else if (rdy_cnt_q == 25'(READY_CYC - 1)) begin
					st_d = SDM_READY; // RULE13
				end
			end
			SDM_READY: begin
				if (!enable_req) begin
					st_d = SDM_OFF; // RULE14
				end
			end
			default: st_d = SDM_OFF;
		endcase
		evt            = '0;
		evt[IRQ_READY] = (st_q == SDM_CHARGE) && (st_d == SDM_READY);
		evt[IRQ_COAST] = en_prev_q & ~enable_req & motor_rotating_i;
		evt[IRQ_FAULT] = fault_clear & ~fault_prev_q;
		evt[IRQ_PARAM] = pc_param_convert_i;
	end

	assign tick = (tick_cnt_q == 24'h0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q         <= SDM_OFF;
			rdy_cnt_q    <= '0;
			tick_cnt_q   <= '0;
			en_prev_q    <= 1'b0;
			fault_prev_q <= 1'b0;
		end else begin
			st_q         <= st_d;
			rdy_cnt_q    <= rdy_cnt_d;
			tick_cnt_q   <= tick_cnt_d;
			en_prev_q    <= enable_req;
			fault_prev_q <= fault_clear;
		end
	end

	// ==========================================================
	// Meter scaling
	logic [15:0]        load_filt;
	logic [15:0]        spd_abs;
	logic [14:0]        span_eff;
	logic [3:0]         volts;
	logic [47:0]        spd_q48, load_q48;
	logic [7:0]         meter [2];
	logic signed [16:0] sdata [2];
	logic [7:0]         scode [2];
	logic [7:0]         code_d [2];

	sdm_load_filter #(
		.TICK_US (TICK_CYC / CYC_PER_US)
	) u_filter (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_i (tick),
		.tc_i   (load_tc),
		.x_i    (load_i),
		.y_o    (load_filt)
	);

	// Divider is wide and combinational; its result is loaded only on the output tick
	always_comb begin
		spd_abs  = speed_fb_i[15] ? 16'(-speed_fb_i) : 16'(speed_fb_i); // RULE1
		span_eff = (spd_span != 15'h0) ? spd_span : top_spd; // RULE2
		if (span_eff == 15'h0) begin
			span_eff = 15'h1;
		end
		volts    = (load_span != 4'h0) ? load_span : 4'(FULL_VOLTS); // RULE6
		spd_q48  = (48'(spd_abs) * CODE_MAX * 48'(spd_trim))
			/ (48'(span_eff) * TRIM_MAX); // RULE5
		load_q48 = (48'(load_filt) * CODE_MAX * 48'(volts) * 48'(load_trim))
			/ 48'(LOAD_120_RAW * FULL_VOLTS * TRIM_MAX); // RULE5 RULE6
		if (force_fs) begin
			spd_q48  = (48'(CODE_MAX) * 48'(spd_trim)) / TRIM_MAX; // RULE4
			load_q48 = (48'(CODE_MAX) * 48'(load_trim)) / TRIM_MAX; // RULE4
		end
		meter[0] = sdm_sat8($signed({1'b0, spd_q48[46:0]})); // RULE18
		meter[1] = sdm_sat8($signed({1'b0, load_q48[46:0]})); // RULE18
	end

	for (genvar c = 0; c < 2; c++) begin : g_chan
		always_comb begin
			if (dn[c] == DN_CUR_CMD) begin
				sdata[c] = 17'(cur_cmd_i);
			end else if (dn[c] == DN_CUR_FB) begin
				sdata[c] = 17'(cur_fb_i);
			end else if (dn[c] == DN_SPEED_FB) begin
				sdata[c] = 17'(speed_fb_i);
			end else if (dn[c] == DN_CTRL_FIRST) begin
				sdata[c] = {1'b0, cmd_q}; // RULE10
			end else if (dn[c] > DN_CTRL_FIRST && dn[c] <= DN_CTRL_LAST) begin
				sdata[c] = {1'b0, ctrl_aux_i[3'(dn[c] - DN_CTRL_FIRST - 8'h01)]}; // RULE10
			end else begin
				sdata[c] = 17'sh0;
			end
			// Meter data uses a fixed channel and ignores gain
			code_d[c] = (dn[c] == DN_METER || force_fs) ? meter[c] : scode[c]; // RULE1 RULE4
		end

		sdm_gain_scale u_scale (
			.data_i (sdata[c]),
			.gain_i (gain[c]),
			.code_o (scode[c])
		);
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dac1_code_o             <= 8'h00;
			dac2_code_o             <= 8'h00;
			dac_strobe_o            <= 1'b0;
			main_circuit_on_o       <= 1'b0;
			ready_on_reached_o      <= 1'b0;
			motor_current_en_o      <= 1'b0;
			fault_clear_request_o   <= 1'b0;
			param_convert_request_o <= 1'b0;
			torque_cap_sel_o        <= 3'h0;
			run_fwd_o               <= 1'b0;
			run_rev_o               <= 1'b0;
			orient_o                <= 1'b0;
			adjust_mode_o           <= 1'b0;
			irq_o                   <= 1'b0;
			wb_ack_o                <= 1'b0;
			wb_dat_o                <= 32'h0;
		end else begin
			if (tick) begin
				dac1_code_o <= code_d[0];
				dac2_code_o <= code_d[1];
			end
			dac_strobe_o            <= tick;
			main_circuit_on_o       <= (st_q != SDM_OFF); // RULE12
			ready_on_reached_o      <= (st_q == SDM_READY);
			motor_current_en_o      <= (st_q == SDM_READY) && !fault_clear; // RULE14 RULE15
			fault_clear_request_o   <= fault_clear; // RULE15
			param_convert_request_o <= cmd_q[CMD_PARAM_BIT]; // RULE17
			torque_cap_sel_o        <= cmd_q[CMD_TCAP_LSB +: 3];
			run_fwd_o               <= (st_q == SDM_READY) && run_fwd_i; // RULE13
			run_rev_o               <= (st_q == SDM_READY) && run_rev_i; // RULE13
			orient_o                <= (st_q == SDM_READY) && orient_i; // RULE13
			adjust_mode_o           <= force_fs; // RULE4
			irq_o                   <= |(stat_q & mask_q);
			wb_ack_o                <= ack_d;
			wb_dat_o                <= rdat_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_meter_zero: assert property (tick && dn[0] == DN_METER && !force_fs // RULE1
		&& speed_fb_i == 16'sh0 |=> dac1_code_o == 8'h00)
		else $error("meter zero speed not at zero code");
	a_span_fallback: assert property (tick && dn[0] == DN_METER && !force_fs // RULE2
		&& spd_span == 15'h0 && top_spd != 15'h0 && spd_abs == 16'(top_spd)
		&& spd_trim == 10'(TRIM_MAX) |=> dac1_code_o == 8'hff)
		else $error("top speed did not reach full scale");
	a_force_trim: assert property (tick && force_fs |=> adjust_mode_o // RULE4 RULE5
		&& dac1_code_o == 8'((CODE_MAX * 32'($past(spd_trim))) / TRIM_MAX))
		else $error("forced full scale code wrong");
	a_unity_gain: assert property (tick && dn[1] == DN_SPEED_FB && gain[1] == 16'sh0 // RULE9
		&& speed_fb_i == 16'sh0010 |=> dac2_code_o == 8'h90)
		else $error("zero gain not treated as unity");
	a_ctrl_word: assert property (tick && dn[0] == DN_CTRL_FIRST && gain[0] == 16'sh0 // RULE10
		&& cmd_q == 16'h0001 |=> dac1_code_o == 8'h81)
		else $error("command word not output whole");
	a_main_on: assert property ($rose(enable_req) |=> ##1 main_circuit_on_o) // RULE12
		else $error("main circuit not switched on");
	a_run_gate: assert property (run_fwd_o || run_rev_o || orient_o // RULE13
		|-> $past(st_q) == SDM_READY)
		else $error("run command passed before ready");
	a_coast_cut: assert property (motor_rotating_i && $fell(enable_req) // RULE14
		|=> ##[0:1] !motor_current_en_o)
		else $error("current not cut on enable drop");
	a_fault_clear: assert property (gp_fault |=> fault_clear_request_o // RULE15 RULE16
		&& !motor_current_en_o)
		else $error("fault clear not applied");
	a_param_set: assert property (pc_param_convert_i |=> ##1 param_convert_request_o) // RULE17
		else $error("param convert bit not set");

endmodule

// ===== src/sdm_pkg.sv
package sdm_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
	localparam int unsigned READY_DELAY_MS  = 1000;
	localparam int unsigned READY_DELAY_CYC = CYC_PER_US * 1000 * READY_DELAY_MS;
	localparam int unsigned OUT_CYCLE_US    = 444;
	localparam int unsigned OUT_CYCLE_CYC   = CYC_PER_US * OUT_CYCLE_US;
	localparam int unsigned LOAD_TC_STEP_US = 3500;
	localparam int unsigned LOAD_TC_ZERO_US = 226_000;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CMD      = 8'h00;
	localparam logic [7:0] OFS_CHAN_SEL = 8'h04;
	localparam logic [7:0] OFS_GAIN1    = 8'h08;
	localparam logic [7:0] OFS_GAIN2    = 8'h0c;
	localparam logic [7:0] OFS_TOPSPD   = 8'h10;
	localparam logic [7:0] OFS_SPDSPAN  = 8'h14;
	localparam logic [7:0] OFS_LOADTC   = 8'h18;
	localparam logic [7:0] OFS_SPDTRIM  = 8'h1c;
	localparam logic [7:0] OFS_LOADTRIM = 8'h20;
	localparam logic [7:0] OFS_LOADSPAN = 8'h24;
	localparam logic [7:0] OFS_GPSEL_LO = 8'h28;
	localparam logic [7:0] OFS_GPSEL_HI = 8'h2c;
	localparam logic [7:0] OFS_STATE    = 8'h30;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h34;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h38;
	localparam int unsigned CFG_WORDS   = 12;

	// Reset values and writable masks, indexed by offset / 4
	localparam logic [31:0] CFG_RST [CFG_WORDS] = '{32'h0, 32'h0, 32'h0, 32'h0,
		32'h0000_1770, 32'h0, 32'h0, 32'h0000_03aa, 32'h0000_03aa, 32'h0, 32'h0, 32'h0};
	localparam logic [31:0] CFG_MASK [CFG_WORDS] = '{32'h0000_0000, 32'h0001_ffff,
		32'h0000_ffff, 32'h0000_ffff, 32'h0000_7fff, 32'h0000_7fff, 32'h0000_7fff,
		32'h0000_03ff, 32'h0000_03ff, 32'h0000_000f, 32'h3fff_ffff, 32'h3fff_ffff};

	// ==========================================================
	// Fields and codes
	localparam int unsigned CMD_ENABLE_BIT = 0;
	localparam int unsigned CMD_PARAM_BIT  = 6;
	localparam int unsigned CMD_FAULT_BIT  = 7;
	localparam int unsigned CMD_TCAP_LSB   = 8;
	localparam int unsigned SEL_FORCE_BIT  = 16;
	localparam int unsigned GP_INPUTS      = 12;
	localparam int unsigned GP_SEL_W       = 5;
	localparam logic [4:0]  GP_FAULT_CLEAR = 5'h09;
	localparam int unsigned IRQ_W          = 4;
	localparam int unsigned IRQ_READY      = 0;
	localparam int unsigned IRQ_COAST      = 1;
	localparam int unsigned IRQ_FAULT      = 2;
	localparam int unsigned IRQ_PARAM      = 3;
	localparam logic [7:0]  DN_METER       = 8'h00;
	localparam logic [7:0]  DN_CUR_CMD     = 8'h02;
	localparam logic [7:0]  DN_CUR_FB      = 8'h03;
	localparam logic [7:0]  DN_SPEED_FB    = 8'h04;
	localparam logic [7:0]  DN_CTRL_FIRST  = 8'h50;
	localparam logic [7:0]  DN_CTRL_LAST   = 8'h57;
	localparam int unsigned CODE_MAX       = 255;
	localparam int unsigned CODE_MID       = 128;
	localparam int unsigned GAIN_UNITY     = 256;
	localparam int unsigned GAIN_SHIFT     = 8;
	localparam int unsigned TRIM_MAX       = 1000;
	localparam int unsigned FULL_VOLTS     = 10;
	localparam int unsigned LOAD_120_RAW   = 4915;

	typedef enum logic [2:0] {
		SDM_OFF    = 3'b001,
		SDM_CHARGE = 3'b010,
		SDM_READY  = 3'b100
	} sdm_ready_t;

	// Clamp to the converter's unsigned code range
	function automatic logic [7:0] sdm_sat8(input logic signed [47:0] v);
		if (v < 0) begin
			return 8'h00;
		end else if (v > 48'sd255) begin
			return 8'hff;
		end
		return v[7:0];
	endfunction

	function automatic logic [31:0] sdm_lane(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

// ===== src/sdm_gain_scale.sv
`timescale 1ns/1ns
module sdm_gain_scale
	import sdm_pkg::*;
(
	// Data and gain
	input  wire logic signed [16:0] data_i,
	input  wire logic signed [15:0] gain_i,
	// Result
	output logic             [7:0]  code_o
);
	import sdm_pkg::*;

	logic signed [16:0] gain_eff;
	logic signed [47:0] prod;

	always_comb begin
		// Zero gain means unity
		gain_eff = (gain_i == 16'sh0) ? 17'(GAIN_UNITY) : 17'(gain_i); // RULE9
		prod     = 48'(data_i) * 48'(gain_eff); // RULE8
		// Output mid-scale sits at zero data
		// Signed offset keeps the sum signed, so the shift stays arithmetic
		code_o   = sdm_sat8((prod >>> GAIN_SHIFT) + $signed(48'(CODE_MID))); // RULE7 RULE18
	end

endmodule

// ===== src/sdm_load_filter.sv
`timescale 1ns/1ns
module sdm_load_filter
	import sdm_pkg::*;
#(
	parameter int unsigned TICK_US = sdm_pkg::OUT_CYCLE_US
)(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Sample
	input  wire logic        tick_i,
	input  wire logic [14:0] tc_i,
	input  wire logic [15:0] x_i,
	output logic      [15:0] y_o
);
	import sdm_pkg::*;

	localparam int unsigned ZERO_TICKS = LOAD_TC_ZERO_US / TICK_US;

	logic [31:0] tau_ticks;
	logic [3:0]  shift;
	logic [35:0] acc_q, acc_d;

	// Power-of-two time constant keeps the filter free of a divider
	always_comb begin
		tau_ticks = (tc_i == 15'h0) ? 32'(ZERO_TICKS) // RULE3
			: 32'((64'(tc_i) * LOAD_TC_STEP_US) / TICK_US); // RULE3
		shift = 4'h0;
		for (int i = 1; i < 16; i++) begin
			if (tau_ticks >= (32'h1 << i)) begin
				shift = 4'(i);
			end
		end
		acc_d = acc_q;
		if (tick_i) begin
			acc_d = acc_q + 36'(x_i) - (acc_q >> shift);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_d;
		end
	end

	assign y_o = 16'(acc_q >> shift);

	a_filter_zero_tc: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
		(tc_i == 15'h0) |-> (tau_ticks == 32'(ZERO_TICKS)))
		else $error("zero time constant not mapped to default");

endmodule

// ===== tb/sdm_nc_model.sv
`timescale 1ns/1ns
module sdm_nc_model (
	// Clock
	input  wire logic        clk_i,
	// Bus toward the drive
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic [7:0]       wb_adr_o,
	output logic [3:0]       wb_sel_o,
	output logic [31:0]      wb_dat_o,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i
);
	// ==========================================================
	// Idle bus
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o  = 1'b0;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'hf;
		wb_dat_o = 32'h0;
	end

	// ==========================================================
	// One classic cycle, latency taken from ack
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o  <= we;
		wb_sel_o <= 4'hf;
		wb_adr_o <= adr;
		wb_dat_o <= wd;
		do @(posedge clk_i); while (wb_ack_i !== 1'b1);
		rd = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		wb_we_o  <= 1'b0;
		// Released lines must not keep the last value
		wb_adr_o <= ~adr;
		wb_dat_o <= ~wd;
	endtask

	// ==========================================================
	// Command word one: enable, fault clear, torque caps
	task automatic command(input logic en, input logic flt, input logic [2:0] cap);
		logic [31:0] rd;
		xfer(1'b1, 8'h00, {21'h0, cap, flt, 6'h0, en}, rd);
	endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin \
	cmp_count++; \
	if ((gt) !== (ex)) begin \
		errors++; \
		$display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
	end \
end
module tb_top;
	import sdm_pkg::*;
	// ==========================================================
	// Signals
	logic               clk_i, rst_i, cyc, stb, we, ack, irq, strb;
	logic [7:0]         adr, dac1, dac2;
	logic [3:0]         sel;
	logic [31:0]        wdat, rdat;
	logic signed [15:0] spd, cur;
	logic [6:0][15:0]   aux;
	logic               rot, fwd, rev, ori, pcp, mc_on, rdy, cur_en, flt, param_convert_request;
	logic               fwd_o, rev_o, ori_o, adj;
	logic [2:0]         cap;
	logic [11:0]        gp;
	logic [15:0]        ld;
	int                 errors, cmp_count, tcnt;

	sdm_top #(.READY_CYC(20), .TICK_CYC(40)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq_o(irq), .speed_fb_i(spd), .cur_cmd_i(cur), .cur_fb_i(16'sh0), .load_i(ld),
		.ctrl_aux_i(aux), .motor_rotating_i(rot), .run_fwd_i(fwd), .run_rev_i(rev),
		.orient_i(ori), .pc_param_convert_i(pcp), .gp_in_i(gp), .dac1_code_o(dac1),
		.dac2_code_o(dac2), .dac_strobe_o(strb), .main_circuit_on_o(mc_on),
		.ready_on_reached_o(rdy), .motor_current_en_o(cur_en), .fault_clear_request_o(flt),
		.param_convert_request_o(param_convert_request), .torque_cap_sel_o(cap), .run_fwd_o(fwd_o),
		.run_rev_o(rev_o), .orient_o(ori_o), .adjust_mode_o(adj));

	sdm_nc_model i_nc (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
		.wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));

	// ==========================================================
	// Clock, timeout and closing
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		tcnt <= tcnt + 1;
		if (tcnt == 20000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Access helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		i_nc.xfer(1'b1, a, d, r);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
		logic [31:0] r;
		i_nc.xfer(1'b0, a, 32'h0, r);
		`CHK(nm, ex, r)
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// Second strobe guarantees codes built from the new settings
	task automatic ticks();
		repeat (2) @(posedge clk_i iff strb);
		#1;
	endtask

	// ==========================================================
	// Tests
	initial begin
		errors = 0;
		cmp_count = 0;
		tcnt = 0;
		{spd, cur, rot, fwd, rev, ori, pcp, gp} = '0;
		aux = '0;
		ld = '0;
		aux[0] = 16'h0010;
		rst_i = 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc("top_speed", OFS_TOPSPD, 32'h1770);
		rdc("speed_trim", OFS_SPDTRIM, 32'h3aa);
		rdc("cmd_word", OFS_CMD, 32'h0);
		rdc("unmapped", 8'hfc, 32'h0);
		$display("test registers done");
		{fwd, rev, ori} <= 3'b111;
		rot <= 1'b1;
		wr(OFS_IRQ_MASK, 32'h1);
		i_nc.command(1'b1, 1'b0, 3'h7);
		cycles(3);
		`CHK("main_on", 1'b1, mc_on)
		`CHK("run_early", 3'h0, {fwd_o, rev_o, ori_o})
		`CHK("caps", 3'h7, cap)
		cycles(25);
		`CHK("ready", 1'b1, rdy)
		`CHK("run_late", 3'h7, {fwd_o, rev_o, ori_o})
		`CHK("cur_on", 1'b1, cur_en)
		`CHK("irq_set", 1'b1, irq)
		wr(OFS_IRQ_STAT, 32'h1);
		cycles(2);
		`CHK("irq_clr", 1'b0, irq)
		i_nc.command(1'b0, 1'b0, 3'h0);
		cycles(3);
		`CHK("cur_drop", 1'b0, cur_en)
		`CHK("main_off", 1'b0, mc_on)
		i_nc.command(1'b1, 1'b0, 3'h0);
		cycles(25);
		i_nc.command(1'b1, 1'b1, 3'h0);
		cycles(3);
		`CHK("fault_req", 1'b1, flt)
		`CHK("cur_flt", 1'b0, cur_en)
		i_nc.command(1'b1, 1'b0, 3'h0);
		wr(OFS_GPSEL_LO, 32'h0000_0120);
		gp <= 12'h002;
		cycles(3);
		`CHK("gp_fault", 1'b1, flt)
		pcp <= 1'b1;
		cycles(1);
		pcp <= 1'b0;
		cycles(2);
		`CHK("param", 1'b1, param_convert_request)
		$display("test sequence done");
		cur <= 16'sd100;
		wr(OFS_CHAN_SEL, 32'h0000_0202);
		wr(OFS_GAIN2, 32'h0000_ff00);
		ticks();
		`CHK("ch1_unity", 8'd228, dac1)
		`CHK("ch2_neg", 8'd28, dac2)
		cur <= 16'sd1000;
		ticks();
		`CHK("ch1_sat", 8'hff, dac1)
		`CHK("ch2_sat", 8'h00, dac2)
		spd <= -16'sd3000;
		wr(OFS_CHAN_SEL, 32'h0000_5100);
		ticks();
		`CHK("speedo", 8'd119, dac1)
		`CHK("ctrl_word", 8'd112, dac2)
		wr(OFS_SPDSPAN, 32'h0000_0bb8);
		ticks();
		`CHK("span", 8'd239, dac1)
		wr(OFS_SPDTRIM, 32'h0000_03e8);
		wr(OFS_CHAN_SEL, 32'h0001_0000);
		ticks();
		`CHK("adjust", 1'b1, adj)
		`CHK("force_spd", 8'hff, dac1)
		`CHK("force_load", 8'd239, dac2)
		wr(OFS_GAIN2, 32'h0);
		wr(OFS_SPDSPAN, 32'h0);
		spd <= 16'sd16;
		wr(OFS_CHAN_SEL, 32'h0000_0400);
		ticks();
		`CHK("spd_unity", 8'h90, dac2)
		spd <= 16'sd6000;
		ld <= 16'd4915;
		wr(OFS_CHAN_SEL, 32'h0);
		ticks();
		`CHK("fallback", 8'hff, dac1)
		// Long default time constant: a few microseconds in, the meter is still at zero
		`CHK("load_slow", 8'h00, dac2)
		$display("test converter done");
		wrap_up();
	end
endmodule
